// File: core/sram_host.sv
// Behaviour
// - strobe stays high through every read
// - never drive while memory may drive
// - every cycle lasts the least cycle time
// - strobe held low the least pulse width
// - select held low before write end
// - retention entered by raising select, no delay
`include "sram_host_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sram_host #(
  parameter sram_host_pkg::grade_t GRADE = sram_host_pkg::grade_fast,
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W
) (
  input wire logic clk,
  input wire logic nrst,
  // user side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  input wire logic retain_req,
  output logic retain_active,
  // memory pins
  output logic [ADDR_W-1:0] word_address,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  input wire logic [DATA_W-1:0] data_port_in,
  output logic [DATA_W-1:0] data_port_out,
  output logic data_port_oe
);
  import sram_host_pkg::*;

  // ==========================================================
  // timing in cycles
  localparam int TW = `SRAM_TIMER_W;
  localparam bit FAST = (GRADE == grade_fast);
  localparam int CYCLE_NS = FAST ? `SRAM_CYCLE_FAST_NS :
    `SRAM_CYCLE_SLOW_NS;
  localparam int CS_ACC_NS = FAST ? `SRAM_CS_ACCESS_FAST_NS :
    `SRAM_CS_ACCESS_SLOW_NS;
  localparam int OE_ACC_NS = FAST ? `SRAM_OE_ACCESS_FAST_NS :
    `SRAM_OE_ACCESS_SLOW_NS;
  localparam int WP_NS = FAST ? `SRAM_WRITE_PULSE_FAST_NS :
    `SRAM_WRITE_PULSE_SLOW_NS;
  localparam int CW_NS = FAST ? `SRAM_SELECT_TO_END_FAST_NS :
    `SRAM_SELECT_TO_END_SLOW_NS;
  localparam int REL_NS = FAST ? `SRAM_RELEASE_FAST_NS :
    `SRAM_RELEASE_SLOW_NS;

  localparam int CYCLE_CYC = `SRAM_CYC_UP(CYCLE_NS);
  localparam int CS_ACC_CYC = `SRAM_CYC_UP(CS_ACC_NS);
  localparam int OE_ACC_CYC = `SRAM_CYC_UP(OE_ACC_NS);
  localparam int WP_CYC = `SRAM_CYC_UP(WP_NS);
  localparam int CW_CYC = `SRAM_CYC_UP(CW_NS);
  localparam int REL_CYC = `SRAM_CYC_UP(REL_NS);
  localparam int RETAIN_CYC = `SRAM_CYC_UP(`SRAM_DESELECT_TO_RETENTION_NS);

  // select and enable fall together, so the longer access rules
  localparam int ACC_CYC = CS_ACC_CYC > OE_ACC_CYC ? CS_ACC_CYC :
    OE_ACC_CYC;
  localparam int RD_CYC = ACC_CYC > CYCLE_CYC ? ACC_CYC : CYCLE_CYC;
  localparam int WPW_CYC = WP_CYC > CW_CYC ? WP_CYC : CW_CYC;
  localparam int WR_CYC = WPW_CYC > CYCLE_CYC ? WPW_CYC : CYCLE_CYC;

  localparam logic [TW-1:0] RD_LOAD = TW'(RD_CYC - 1);
  localparam logic [TW-1:0] WR_LOAD = TW'(WR_CYC - 1);
  localparam logic [TW-1:0] REL_LOAD = TW'(REL_CYC - 1);
  localparam logic [TW-1:0] WAKE_LOAD = TW'(CYCLE_CYC - 1);
  localparam logic [TW-1:0] RETAIN_LOAD = TW'(RETAIN_CYC - 1);

  // ==========================================================
  // state and decode
  state_t state;
  state_t next_state;
  logic timer_done;
  logic timer_load;
  logic [TW-1:0] timer_value;

  wire accept = req_valid && req_ready;
  wire start_read = accept && !req_write;
  wire start_write = accept && req_write;
  wire enter_retain = (state == st_idle) && retain_req && !req_valid;
  wire read_end = (state == st_read) && timer_done;
  wire write_end = (state == st_write) && timer_done;
  wire recover_end = (state == st_recover) && timer_done;
  wire wake_end = (state == st_wake) && timer_done;
  wire leave_retain = (state == st_retain) && !retain_req;

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (start_read) begin
          next_state = st_read;
        end else if (start_write) begin
          next_state = st_write;
        end else if (enter_retain) begin
          next_state = st_retain;
        end
      end
      st_read: begin
        if (read_end) begin
          next_state = st_recover;
        end
      end
      st_write: begin
        if (write_end) begin
          next_state = st_recover;
        end
      end
      st_recover: begin
        if (recover_end) begin
          next_state = st_idle;
        end
      end
      st_retain: begin
        if (leave_retain) begin
          next_state = st_wake;
        end
      end
      st_wake: begin
        if (wake_end) begin
          next_state = st_idle;
        end
      end
      // two spare codes; fall back to idle, pins go released
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  // ==========================================================
  // timer loads: every phase lasts its full count
  assign timer_load = start_read || start_write || read_end ||
    write_end || enter_retain || leave_retain;
  assign timer_value = start_read ? RD_LOAD :
    start_write ? WR_LOAD :
    leave_retain ? WAKE_LOAD :
    enter_retain ? RETAIN_LOAD :
    REL_LOAD;

  cycle_timer #(
    .W(TW)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .load(timer_load),
    .value(timer_value),
    .done(timer_done)
  );

  // ==========================================================
  // pin values
  // in every write, select and strobe move on the same edge, so the
  // memory never sees a selected read around a write
  wire next_cs_n = !(start_read || start_write ||
    ((state == st_read || state == st_write) && !timer_done));
  wire next_oe_n = !(start_read ||
    ((state == st_read) && !timer_done));
  wire next_we_n = !(start_write ||
    ((state == st_write) && !timer_done));
  wire next_drive = start_write ||
    ((state == st_write) && !timer_done);
  wire next_ready = (next_state == st_idle) && !retain_req;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_port_oe <= 1'b0;
    end else begin
      state <= next_state;
      chip_select_n <= next_cs_n;
      output_enable_n <= next_oe_n;
      write_strobe_n <= next_we_n;
      data_port_oe <= next_drive;
    end
  end

  // address and data held for the whole access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_address <= '0;
      data_port_out <= '0;
    end else if (accept) begin
      word_address <= req_addr;
      data_port_out <= req_wdata;
    end
  end

  // ==========================================================
  // user handshake
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      retain_active <= 1'b0;
    end else begin
      req_ready <= next_ready;
      rsp_valid <= read_end;
      retain_active <= (next_state == st_retain);
      if (read_end) begin
        rsp_rdata <= data_port_in;
      end
    end
  end

endmodule // sram_host

`default_nettype wire

// File: core/sram_host_cfg.svh
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH

// ==========================================================
// geometry
`define SRAM_ADDR_W 19
`define SRAM_DATA_W 8
`define SRAM_WORDS 524288

// ==========================================================
// clock
`define SRAM_CLK_PERIOD_NS 40

// ==========================================================
// timing, fast grade, upper supply range (ns)
`define SRAM_CYCLE_FAST_NS 70
`define SRAM_CS_ACCESS_FAST_NS 70
`define SRAM_OE_ACCESS_FAST_NS 35
`define SRAM_WRITE_PULSE_FAST_NS 50
`define SRAM_SELECT_TO_END_FAST_NS 60
`define SRAM_RELEASE_FAST_NS 30

// ==========================================================
// timing, slow grade, upper supply range (ns)
`define SRAM_CYCLE_SLOW_NS 85
`define SRAM_CS_ACCESS_SLOW_NS 85
`define SRAM_OE_ACCESS_SLOW_NS 45
`define SRAM_WRITE_PULSE_SLOW_NS 55
`define SRAM_SELECT_TO_END_SLOW_NS 70
`define SRAM_RELEASE_SLOW_NS 35

// ==========================================================
// retention
`define SRAM_DESELECT_TO_RETENTION_NS 0

// ==========================================================
// least time in ns to whole clock cycles, at least one
`define SRAM_CYC_UP(ns) (((ns) + `SRAM_CLK_PERIOD_NS - 1) / \
  `SRAM_CLK_PERIOD_NS > 0 ? ((ns) + `SRAM_CLK_PERIOD_NS - 1) / \
  `SRAM_CLK_PERIOD_NS : 1)

// ==========================================================
// timer width
`define SRAM_TIMER_W 4

`endif

// File: core/sram_host_pkg.sv
package sram_host_pkg;

  typedef enum logic {
    grade_fast,
    grade_slow
  } grade_t;

  typedef enum logic [2:0] {
    st_idle,
    st_read,
    st_write,
    st_recover,
    st_retain,
    st_wake
  } state_t;

endpackage

// File: core/cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// down counter; done while it rests at zero
module cycle_timer #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);

  logic [W-1:0] count;

  assign done = (count == '0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (!done) begin
      count <= count - 1'b1;
    end
  end

endmodule // cycle_timer

`default_nettype wire

// File: bench/sram_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// pin and handshake checks, fast grade
module sram_host_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic retain_active,
  input wire logic [18:0] word_address,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic data_port_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_strobe_high: assert property (
    !output_enable_n |-> write_strobe_n) else $error("strobe low");
  a_no_contention: assert property (
    !output_enable_n |-> !data_port_oe) else $error("both drive");
  a_write_start: assert property (
    $fell(write_strobe_n) |-> $fell(chip_select_n)) else $error("start");
  a_write_end: assert property (
    $rose(write_strobe_n) |-> $rose(chip_select_n) && !data_port_oe)
    else $error("end");
  a_enable_off_write: assert property (
    !write_strobe_n |-> output_enable_n) else $error("enable in write");
  a_select_cycle: assert property (
    $fell(chip_select_n) |-> !chip_select_n[*2] ##1 chip_select_n[*2])
    else $error("select width");
  a_strobe_width: assert property (
    $fell(write_strobe_n) |=> !write_strobe_n) else $error("pulse");
  a_addr_steady: assert property (
    !$past(chip_select_n) |-> $stable(word_address)) else $error("addr");
  a_read_latency: assert property (
    req_valid && req_ready && !req_write |-> ##3 rsp_valid)
    else $error("latency");
  a_retain_idle: assert property (
    retain_active |-> chip_select_n && !req_ready) else $error("retain");
  a_wake_wait: assert property (
    $fell(retain_active) |-> !req_ready) else $error("wake");
  a_turnaround_gap: assert property (
    $rose(output_enable_n) |-> !data_port_oe ##1 !data_port_oe)
    else $error("no release gap");
  cover property ($rose(rsp_valid));
  cover property ($fell(write_strobe_n));
  cover property ($rose(retain_active));
endmodule // sram_host_properties

bind sram_host sram_host_properties i_props (.clk(clk), .nrst(nrst),
  .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .retain_active(retain_active),
  .word_address(word_address), .chip_select_n(chip_select_n),
  .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
  .data_port_oe(data_port_oe));
`default_nettype wire

// File: bench/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// memory on the pins
module sram_model #(
  parameter int ACC_NS = 70
) (
  input wire logic [18:0] word_address,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe
);
  logic [7:0] mem [524288];
  logic [7:0] wd;
  logic [18:0] wa;
  wire rd_late;
  wire rd = !chip_select_n && !output_enable_n && write_strobe_n;
  wire wr = !chip_select_n && !write_strobe_n;
  assign #(ACC_NS) rd_late = rd;
  assign data_oe = rd && rd_late;
  // released port shows the inverse, so stale data never matches
  assign data_out = data_oe ? mem[word_address] : ~mem[word_address];
  always @(posedge wr) begin
    #20;
    wa = word_address;
    wd = data_in;
  end
  always @(negedge wr) mem[wa] = wd;
endmodule // sram_model
`default_nettype wire

// File: bench/sram_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module sram_host_bench;
  logic clk, nrst, req_valid, req_write, retain_req;
  logic [18:0] req_addr;
  logic [7:0] req_wdata;
  wire req_ready, rsp_valid, retain_active, chip_select_n, mem_oe;
  wire output_enable_n, write_strobe_n, data_port_oe;
  wire [18:0] word_address;
  wire [7:0] rsp_rdata, data_port_out, mem_q, data_port;
  logic [7:0] ref_mem [int];
  logic [31:0] seed = 32'h75C1CB83;
  int bad_count, total_checks;
  // two drivers at once read as unknown
  assign data_port = (data_port_oe && mem_oe) ? 8'hXX :
    data_port_oe ? data_port_out : mem_q;
  sram_host i_sram_host (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .retain_req(retain_req), .retain_active(retain_active),
    .word_address(word_address), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .data_port_in(data_port), .data_port_out(data_port_out),
    .data_port_oe(data_port_oe));
  sram_model i_sram_model (.word_address(word_address),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .data_in(data_port),
    .data_out(mem_q), .data_oe(mem_oe));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  // called at a falling edge; request held until taken
  task automatic access(input logic wr, input logic [18:0] a,
      input logic [7:0] d);
    int n;
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(req_ready, 1);
    @(negedge clk);
    req_valid = 0;
    if (wr) begin
      ref_mem[a] = d;
      // one edge apart so the next request never meets this release
      @(negedge clk);
    end else begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      check(rsp_valid, 1);
      check(rsp_rdata, ref_mem[a]);
      @(negedge clk);
      check(rsp_valid, 0);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    nrst = 0;
    req_valid = 0;
    req_write = 0;
    req_addr = 0;
    req_wdata = 0;
    retain_req = 0;
    repeat (12) @(negedge clk);
    nrst = 1;
    check(chip_select_n, 1);
    access(1, 19'h00000, 8'hA5);
    access(1, 19'h7FFFF, 8'h5A);
    access(0, 19'h00000, 8'h00);
    access(0, 19'h7FFFF, 8'h00);
    $display("boundary test done");
    // back-to-back write then read of random words
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      access(1, seed[18:0], seed[26:19]);
      access(0, seed[18:0], 8'h00);
    end
    $display("random test done");
    retain_req = 1;
    repeat (4) @(negedge clk);
    check(retain_active, 1);
    check(chip_select_n, 1);
    retain_req = 0;
    @(negedge clk);
    check(req_ready, 0);
    @(negedge clk);
    check(req_ready, 0);
    access(0, 19'h7FFFF, 8'h00);
    $display("retention test done");
    stop_test();
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule // sram_host_bench
`default_nettype wire
